// ==== hw/fpmac_top.sv ====
// Purpose: Front-panel mode, screen saver, SWR alarm, power display and trim control.
// Assumes: Buttons active high and asynchronous; APB slave with zero wait states.
// Notes: Non-volatile storage sits outside, reached through ports.
`include "fpmac_regs.svh"

module fpmac_top #(
    parameter longint DIM_CYC = (`FPMAC_DIM_MS / 1000) * `FPMAC_CLK_HZ, // Dim delay.
    parameter longint SCROLL_CYC = (`FPMAC_SCROLL_MS / 1000) * `FPMAC_CLK_HZ, // Scroll delay.
    parameter longint SNOOZE_CYC = (`FPMAC_SNOOZE_MS / 1000) * `FPMAC_CLK_HZ, // Snooze span.
    parameter int HOLD_CYC = `FPMAC_HOLD_MS * (`FPMAC_CLK_HZ / 1000), // Tap versus hold.
    parameter int REPEAT_CYC = `FPMAC_REPEAT_MS * (`FPMAC_CLK_HZ / 1000), // Hold repeat.
    parameter int DEB_CYC = `FPMAC_DEBOUNCE_MS * (`FPMAC_CLK_HZ / 1000) // Debounce time.
) (
    input wire logic clk_sys, // System clock.
    input wire logic rst_n, // Async reset.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    input wire logic btnMode, // Mode button.
    input wire logic btnAlarm, // Alarm button.
    input wire logic btnPeak, // Peak/average/tune button.
    input wire logic txActive, // Transmitting.
    input wire logic [3:0] txBand, // Band index.
    input wire logic [2:0] nvMode, // Stored mode index.
    input wire logic nvValid, // Stored index valid.
    output logic [2:0] nvModeWr, // Mode index to store.
    output logic nvModeWe, // Store strobe, one cycle.
    output logic [4:0] dispMode, // One-hot main display mode.
    output logic showReturnLoss, // Return loss shown.
    output logic rearInputSel, // Rear input used.
    output logic reactAbs, // Reactance magnitude.
    output logic dimDisplay, // First screen-saver step.
    output logic scrollCall, // Second screen-saver step.
    output logic [2:0] alarmSel, // Set-point index 0 off to 5 user.
    output logic [5:0] alarmThresh, // Active threshold in tenths, 0 when off.
    output logic showUserValue, // User value shown.
    output logic alarmSnoozed, // Alarm suppressed.
    output logic swrAverage, // Show averaged SWR.
    output logic [2:0] pwrStyle, // One-hot average, peak, tune.
    output logic [7:0] pwrSuffix, // Power suffix char.
    output logic [8:0] peakHoldCs, // Peak hold, cs.
    output logic [3:0] barSpanDb, // Active bargraph span in dB.
    output logic [3:0] bandShown, // Band shown.
    output logic [10:0] masterTrim, // Master trim.
    output logic [10:0] bandTrim // Band fine trim.
);

    // ----------------------------------------
    // Parameter checks.
    // ----------------------------------------
    initial begin
        if (DEB_CYC < 1 || HOLD_CYC <= DEB_CYC || DIM_CYC >= SCROLL_CYC || SNOOZE_CYC < 1) begin
            $error("fpmac_top: unusable timing parameters.");
        end
    end

    // ----------------------------------------
    // Button synchronising, debounce and press classification.
    // ----------------------------------------
    logic [2:0] btnRaw; // Raw buttons, bit 0 mode, 1 alarm, 2 peak.
    logic [2:0] btnTap; // Short tap released, one cycle.
    logic [2:0] btnStep; // Hold or repeat step, one cycle.
    assign btnRaw = {btnPeak, btnAlarm, btnMode};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : gBtn
            logic syncA_q; // First synchroniser stage.
            logic syncB_q; // Second synchroniser stage.
            logic stable_q; // Debounced level.
            logic [31:0] debCnt_q; // Debounce counter.
            logic [31:0] pressCnt_q; // Press length counter.
            fpmac_pkg::fpmac_btn_t st_q; // Classifier state.
            wire diff = syncB_q != stable_q; // Level differs.
            wire pressLong = pressCnt_q >= 32'(HOLD_CYC - 1); // Hold threshold met.
            wire repDue = pressCnt_q >= 32'(REPEAT_CYC - 1); // Repeat due.
            // Debounce: accept a level once steady long enough.
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    syncA_q <= 1'b0;
                    syncB_q <= 1'b0;
                    stable_q <= 1'b0;
                    debCnt_q <= '0;
                end else begin
                    syncA_q <= btnRaw[gi];
                    syncB_q <= syncA_q;
                    debCnt_q <= diff ? debCnt_q + 32'h1 : '0;
                    if (diff && debCnt_q >= 32'(DEB_CYC - 1)) begin
                        stable_q <= syncB_q;
                    end
                end
            end
            // Classify: nothing acts until the press is known short or long.
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    st_q <= fpmac_pkg::BTN_IDLE;
                    pressCnt_q <= '0;
                end else begin
                    case (st_q)
                        fpmac_pkg::BTN_IDLE: begin
                            pressCnt_q <= '0;
                            if (stable_q) st_q <= fpmac_pkg::BTN_DOWN;
                        end
                        fpmac_pkg::BTN_DOWN: begin
                            pressCnt_q <= pressCnt_q + 32'h1;
                            if (!stable_q) begin
                                st_q <= fpmac_pkg::BTN_IDLE; // Tap.
                            end else if (pressLong) begin
                                st_q <= fpmac_pkg::BTN_HELD;
                                pressCnt_q <= '0;
                            end
                        end
                        fpmac_pkg::BTN_HELD: begin
                            pressCnt_q <= repDue ? '0 : pressCnt_q + 32'h1;
                            if (!stable_q) st_q <= fpmac_pkg::BTN_IDLE;
                        end
                        default: st_q <= fpmac_pkg::BTN_IDLE;
                    endcase
                end
            end
            assign btnTap[gi] = (st_q == fpmac_pkg::BTN_DOWN) && !stable_q;
            assign btnStep[gi] = stable_q && (((st_q == fpmac_pkg::BTN_DOWN) && pressLong)
                                 || ((st_q == fpmac_pkg::BTN_HELD) && repDue));
        end
    endgenerate

    // ----------------------------------------
    // APB decode.
    // ----------------------------------------
    logic [31:0] ctrl_q; // Bit 0 average-during-snooze.
    logic [8:0] holdCfg_q; // Configured peak hold in centiseconds.
    logic [3:0] spanCfg_q; // Configured bargraph span in dB.
    logic [5:0] userAlm_q; // User SWR threshold in tenths.
    logic [10:0] master_q; // Master trim.
    logic [10:0] fine_q [`FPMAC_NUM_BANDS]; // Per-band fine trims.
    logic [3:0] bandSel_q; // Band whose trim is reached over APB.
    logic calUnlock_q; // Data-area programming chosen.
    wire apbWr = psel && penable && pwrite; // Write takes effect.
    wire selCtrl = paddr == `FPMAC_OFS_CTRL;
    wire selStat = paddr == `FPMAC_OFS_STATUS;
    wire selSetup = paddr == `FPMAC_OFS_SETUP;
    wire selTrim = paddr == `FPMAC_OFS_TRIM;
    wire selBand = paddr == `FPMAC_OFS_BAND;
    wire selNv = paddr == `FPMAC_OFS_NVMODE;
    wire mapped = selCtrl | selStat | selSetup | selTrim | selBand | selNv;
    wire [8:0] holdIn = pwdata[8:0]; // Proposed hold.
    wire [3:0] spanIn = pwdata[19:16]; // Proposed span.
    wire [5:0] ualmIn = pwdata[29:24]; // Proposed user threshold.
    wire [10:0] trimIn = pwdata[10:0]; // Proposed trim.
    wire holdOk = holdIn >= `FPMAC_HOLD_MIN_CS && holdIn <= `FPMAC_HOLD_MAX_CS;
    wire spanOk = spanIn >= `FPMAC_SPAN_MIN_DB && spanIn <= `FPMAC_SPAN_MAX_DB;
    wire ualmOk = ualmIn >= `FPMAC_UALM_MIN && ualmIn <= `FPMAC_UALM_MAX;
    wire trimOk = trimIn >= `FPMAC_TRIM_MIN && trimIn <= `FPMAC_TRIM_MAX;
    wire bandOk = bandSel_q < 4'(`FPMAC_NUM_BANDS);
    wire calWr = apbWr && calUnlock_q && trimOk;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Configuration; out-of-range setup fields are ignored.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
            holdCfg_q <= `FPMAC_HOLD_DEF_CS;
            spanCfg_q <= `FPMAC_SPAN_MAX_DB;
            userAlm_q <= `FPMAC_UALM_DEF;
            bandSel_q <= '0;
            calUnlock_q <= 1'b0;
        end else if (apbWr) begin
            if (selCtrl) ctrl_q <= {15'h0000, pwdata[31:16] == `FPMAC_CAL_KEY, 15'h0000, pwdata[0]};
            if (selCtrl) calUnlock_q <= pwdata[31:16] == `FPMAC_CAL_KEY;
            if (selSetup && holdOk) holdCfg_q <= holdIn;
            if (selSetup && spanOk) spanCfg_q <= spanIn;
            if (selSetup && ualmOk) userAlm_q <= ualmIn;
            if (selBand) bandSel_q <= pwdata[3:0];
        end
    end

    // Calibration store: written only while unlocked.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            master_q <= `FPMAC_TRIM_UNITY;
            for (int i = 0; i < `FPMAC_NUM_BANDS; i++) fine_q[i] <= `FPMAC_TRIM_UNITY;
        end else if (calWr) begin
            if (selTrim && !pwdata[16]) master_q <= trimIn;
            if (selTrim && pwdata[16] && bandOk) fine_q[bandSel_q] <= trimIn;
        end
    end

    // ----------------------------------------
    // Mode selection and persistence.
    // ----------------------------------------
    logic [2:0] modeIdx_q; // Main mode index 0 to 4.
    logic restored_q; // Stored mode has been checked.
    logic nvWe_q; // Store strobe.
    wire [2:0] modeNext = (modeIdx_q == 3'h4) ? 3'h0 : modeIdx_q + 3'h1;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modeIdx_q <= 3'h0;
            restored_q <= 1'b0;
            nvWe_q <= 1'b0;
        end else begin
            nvWe_q <= 1'b0;
            if (!restored_q) begin
                restored_q <= 1'b1;
                if (nvValid && nvMode <= 3'h4) modeIdx_q <= nvMode;
            end else if (btnTap[0]) begin
                modeIdx_q <= modeNext;
                nvWe_q <= 1'b1;
            end
        end
    end
    assign nvModeWr = modeIdx_q;
    assign nvModeWe = nvWe_q;
    assign dispMode = 5'(5'h01 << modeIdx_q);
    assign showReturnLoss = dispMode != fpmac_pkg::MODE_DIRECT;
    assign rearInputSel = dispMode == fpmac_pkg::MODE_DIRECT;
    assign reactAbs = 1'b1;

    // ----------------------------------------
    // Screen saver.
    // ----------------------------------------
    logic [39:0] idleCnt_q; // Cycles since last activity.
    wire activity = (|btnRaw) | txActive;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idleCnt_q <= '0;
        end else if (activity) begin
            idleCnt_q <= '0;
        end else if (idleCnt_q < 40'(SCROLL_CYC)) begin
            idleCnt_q <= idleCnt_q + 40'h1;
        end
    end
    assign dimDisplay = idleCnt_q >= 40'(DIM_CYC);
    assign scrollCall = idleCnt_q >= 40'(SCROLL_CYC);

    // ----------------------------------------
    // SWR alarm set-point and snooze.
    // ----------------------------------------
    logic [2:0] almIdx_q; // Set-point index.
    logic [39:0] snzCnt_q; // Snooze cycles remaining.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            almIdx_q <= 3'h0;
            snzCnt_q <= '0;
        end else begin
            if (btnStep[1]) almIdx_q <= (almIdx_q == 3'h5) ? 3'h0 : almIdx_q + 3'h1;
            if (btnTap[1]) begin
                snzCnt_q <= 40'(SNOOZE_CYC);
            end else if (snzCnt_q != '0) begin
                snzCnt_q <= snzCnt_q - 40'h1;
            end
        end
    end
    logic [5:0] almVal; // Threshold in tenths for the selection.
    always_comb begin
        case (almIdx_q)
            3'h1: almVal = 6'h0F;
            3'h2: almVal = 6'h14;
            3'h3: almVal = 6'h19;
            3'h4: almVal = 6'h1E;
            3'h5: almVal = userAlm_q;
            default: almVal = 6'h00;
        endcase
    end
    assign alarmSel = almIdx_q;
    assign alarmThresh = almVal;
    assign showUserValue = almIdx_q == 3'h5;
    assign alarmSnoozed = snzCnt_q != '0;
    assign swrAverage = ctrl_q[0] && alarmSnoozed;

    // ----------------------------------------
    // Power display style.
    // ----------------------------------------
    fpmac_pkg::fpmac_pwr_t pwr_q; // Current style.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= fpmac_pkg::PWR_AVG;
        end else if (btnTap[2]) begin
            case (pwr_q)
                fpmac_pkg::PWR_AVG: pwr_q <= fpmac_pkg::PWR_PEAK;
                fpmac_pkg::PWR_PEAK: pwr_q <= fpmac_pkg::PWR_TUNE;
                default: pwr_q <= fpmac_pkg::PWR_AVG;
            endcase
        end
    end
    wire isPeak = pwr_q == fpmac_pkg::PWR_PEAK;
    wire isTune = pwr_q == fpmac_pkg::PWR_TUNE;
    assign pwrStyle = pwr_q;
    assign pwrSuffix = isPeak ? 8'h57 : (isTune ? 8'h54 : 8'h77);
    assign peakHoldCs = isTune ? `FPMAC_TUNE_HOLD_CS : holdCfg_q;
    assign barSpanDb = isPeak ? `FPMAC_PEAK_SPAN_DB : spanCfg_q;

    // ----------------------------------------
    // Band tracking and trim application.
    // ----------------------------------------
    logic [3:0] band_q; // Last transmit band.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            band_q <= '0;
        end else if (txActive && txBand < 4'(`FPMAC_NUM_BANDS)) begin
            band_q <= txBand;
        end
    end
    assign bandShown = band_q;
    assign masterTrim = master_q;
    assign bandTrim = fine_q[band_q];

    // ----------------------------------------
    // Read mux.
    // ----------------------------------------
    wire [31:0] statWord = {11'h000, band_q, pwr_q, almIdx_q, alarmSnoozed, scrollCall,
                            dimDisplay, 4'h0, modeIdx_q, 1'b0};
    wire [31:0] rdMux = selCtrl ? ctrl_q :
                        selStat ? statWord :
                        selSetup ? {2'b00, userAlm_q, 4'h0, spanCfg_q, 7'h00, holdCfg_q} :
                        selTrim ? {21'h000000, master_q} :
                        selBand ? {5'h00, bandOk ? fine_q[bandSel_q] : 11'h000, 12'h000, bandSel_q} :
                        selNv ? {29'h00000000, modeIdx_q} : 32'h00000000;
    assign prdata = (psel && !pwrite) ? rdMux : 32'h00000000;

endmodule : fpmac_top

// ==== pkg/fpmac_pkg.sv ====
// Purpose: Types shared by the front-panel control block.
// Assumes: Nothing beyond the constants header.
// Notes: Enumerations use one-hot codes.
package fpmac_pkg;
    // Main display modes.
    typedef enum logic [4:0] {
        MODE_NORMAL = 5'h01,
        MODE_VECTOR = 5'h02,
        MODE_POWER = 5'h04,
        MODE_DIRECT = 5'h08,
        MODE_PAR = 5'h10
    } fpmac_mode_t;
    // Numeric power display styles.
    typedef enum logic [2:0] {
        PWR_AVG = 3'h1,
        PWR_PEAK = 3'h2,
        PWR_TUNE = 3'h4
    } fpmac_pwr_t;
    // Button press classifier states.
    typedef enum logic [2:0] {
        BTN_IDLE = 3'h1,
        BTN_DOWN = 3'h2,
        BTN_HELD = 3'h4
    } fpmac_btn_t;
endpackage : fpmac_pkg

// ==== pkg/fpmac_regs.svh ====
// Purpose: Register offsets, reset values, limits and timing in milliseconds.
// Assumes: 100 MHz system clock, APB with 32-bit data.
// Notes: Included by the design module.
//
// How it works
// - Mode press steps five main modes.
// - Press in last mode wraps to first.
// - Mode saved to storage, restored at power-up.
// - Thirty seconds idle dims the display.
// - Two minutes idle scrolls the call sign.
// - Power-level mode shows power and return loss.
// - Direct mode shows rear power, no return loss.
// - Vector mode shows reactance as magnitude.
// - Six alarm set-points selected cyclically.
// - User set-point shows programmed threshold.
// - Held alarm button steps every half second.
// - Alarm tap snoozes one minute, retap restarts.
// - Optional averaged SWR while snoozed.
// - Peak button cycles average, peak, tune.
// - Indicator char W, w or T.
// - Tune mode uses 0.25 s hold.
// - Peak bargraph fixed 13 dB span.
// - Transmit band identified, its trim applied.
// - Master trim times band fine trim.
// - Calibration kept unless data program chosen.
// - Peak hold 0.25 to 5 s, default 2.
// - Bargraph span 3 to 12 dB, default 12.
// - User alarm threshold 1.0 to 5.0.
`ifndef FPMAC_REGS_SVH
`define FPMAC_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------
`define FPMAC_OFS_CTRL 12'h000
`define FPMAC_OFS_STATUS 12'h004
`define FPMAC_OFS_SETUP 12'h008
`define FPMAC_OFS_TRIM 12'h00C
`define FPMAC_OFS_BAND 12'h010
`define FPMAC_OFS_NVMODE 12'h014

// ----------------------------------------
// Reset values and limits (alarm in tenths, hold in centiseconds, span in dB, trims in 0.001).
// ----------------------------------------
`define FPMAC_TRIM_UNITY 11'h3E8
`define FPMAC_TRIM_MIN 11'h36B
`define FPMAC_TRIM_MAX 11'h465
`define FPMAC_HOLD_MIN_CS 9'h019
`define FPMAC_HOLD_MAX_CS 9'h1F4
`define FPMAC_HOLD_DEF_CS 9'h0C8
`define FPMAC_TUNE_HOLD_CS 9'h019
`define FPMAC_SPAN_MIN_DB 4'h3
`define FPMAC_SPAN_MAX_DB 4'hC
`define FPMAC_PEAK_SPAN_DB 4'hD
`define FPMAC_UALM_MIN 6'h0A
`define FPMAC_UALM_MAX 6'h32
`define FPMAC_UALM_DEF 6'h1E
`define FPMAC_NUM_BANDS 11
`define FPMAC_CAL_KEY 16'hCA1D

// ----------------------------------------
// Timing, as printed, in milliseconds; clock in hertz.
// ----------------------------------------
`define FPMAC_CLK_HZ 100000000
`define FPMAC_DEBOUNCE_MS 20
`define FPMAC_HOLD_MS 500
`define FPMAC_REPEAT_MS 500
`define FPMAC_DIM_MS 30000
`define FPMAC_SCROLL_MS 120000
`define FPMAC_SNOOZE_MS 60000

`endif

// ==== tb/fpmac_operator.sv ====
// Purpose: Operator working the three front-panel buttons.
// Assumes: Button 0 mode, 1 alarm, 2 peak/average/tune.
// Notes: Each press starts with a one-cycle contact bounce.
module fpmac_operator (
    input wire logic clk_sys, // Clock.
    output logic btnMode, // Mode button.
    output logic btnAlarm, // Alarm button.
    output logic btnPeak // Peak/average/tune button.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] btnQ = 3'h0; // Pressed buttons.
    assign {btnPeak, btnAlarm, btnMode} = btnQ;
    // Bounce, hold for len cycles, release and rest.
    task automatic press(input int which, input int len);
        @(posedge clk_sys);
        btnQ <= 3'h1 << which;
        @(posedge clk_sys);
        btnQ <= 3'h0;
        @(posedge clk_sys);
        btnQ <= 3'h1 << which;
        repeat (len) @(posedge clk_sys);
        btnQ <= 3'h0;
        repeat (20) @(posedge clk_sys);
    endtask : press
endmodule : fpmac_operator

// ==== tb/fpmac_top_bench.sv ====
// Purpose: Self-checking bench for the front-panel control block.
// Assumes: Shortened timing counts.
// Notes: Stored mode 3 is offered at power-up.
module fpmac_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic txActive = 1'b0, nvValid = 1'b1, pready, pslverr, btnMode, btnAlarm, btnPeak;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] txBand = 4'h0, barSpanDb, bandShown;
    logic [2:0] nvMode = 3'h3, nvModeWr, alarmSel, pwrStyle;
    logic nvModeWe, showReturnLoss, rearInputSel, reactAbs, dimDisplay, scrollCall, err;
    logic showUserValue, alarmSnoozed, swrAverage;
    logic [4:0] dispMode;
    logic [5:0] alarmThresh;
    logic [7:0] pwrSuffix;
    logic [8:0] peakHoldCs;
    logic [10:0] masterTrim, bandTrim;
    logic [7:0] sfx [3] = '{8'h77, 8'h57, 8'h54}; // Average, peak, tune characters.
    int fail_count = 0, n_tests = 0, weCount = 0;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (nvModeWe === 1'b1) weCount++;
    fpmac_top #(.DIM_CYC(200), .SCROLL_CYC(400), .SNOOZE_CYC(300), .HOLD_CYC(50),
        .REPEAT_CYC(40), .DEB_CYC(4)) dut_u (.*);
    fpmac_operator op_u (.clk_sys, .btnMode, .btnAlarm, .btnPeak);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin @(posedge clk_sys); k++; end while (pready !== 1'b1 && k < 64);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic t_modes;
        chk(dispMode, 5'h08);
        chk({rearInputSel, showReturnLoss, reactAbs}, 3'b101);
        for (int i = 4; i <= 7; i++) begin
            op_u.press(0, 10);
            chk(dispMode, 32'h1 << (i % 5));
            chk(nvModeWr, i % 5);
        end
        chk(weCount, 4);
        chk(showReturnLoss, 1'b1);
        op_u.press(0, 80);
        chk(dispMode, 5'h04);
    endtask : t_modes
    task automatic t_style;
        for (int i = 1; i <= 3; i++) begin
            op_u.press(2, 10);
            chk(pwrStyle, 3'h1 << (i % 3));
            chk(pwrSuffix, sfx[i % 3]);
        end
        chk({barSpanDb, peakHoldCs}, {4'hC, 9'h0C8});
    endtask : t_style
    task automatic t_regs;
        apb(1'b1, 12'h008, 32'h2D05_0064);
        apb(1'b1, 12'h008, 32'h3302_01F5);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h2D05_0064);
        chk({barSpanDb, peakHoldCs}, {4'h5, 9'h064});
        apb(1'b1, 12'h00C, 32'h3F0);
        chk(masterTrim, 11'h3E8);
        apb(1'b1, 12'h000, 32'hCA1D_0001);
        apb(1'b1, 12'h00C, 32'h3F0);
        apb(1'b1, 12'h00C, 32'h466);
        chk(masterTrim, 11'h3F0);
        apb(1'b1, 12'h010, 32'h2);
        apb(1'b1, 12'h00C, 32'h0001_0400);
        @(posedge clk_sys);
        txBand <= 4'h2; txActive <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk({bandShown, bandTrim}, {4'h2, 11'h400});
        txActive <= 1'b0;
        apb(1'b0, 12'h020, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
    endtask : t_regs
    task automatic t_alarm;
        op_u.press(1, 230);
        chk({alarmSel, showUserValue, alarmThresh}, {3'h5, 1'b1, 6'h2D});
        op_u.press(1, 70);
        chk({alarmSel, alarmSnoozed}, {3'h0, 1'b0});
    endtask : t_alarm
    task automatic t_snooze;
        op_u.press(1, 10);
        chk({alarmSnoozed, swrAverage}, 2'b11);
        repeat (200) @(posedge clk_sys);
        op_u.press(1, 10);
        repeat (200) @(posedge clk_sys);
        chk(alarmSnoozed, 1'b1);
        repeat (120) @(posedge clk_sys);
        chk({alarmSnoozed, swrAverage}, 2'b00);
    endtask : t_snooze
    task automatic t_saver;
        chk(dimDisplay, 1'b1);
        @(posedge clk_sys);
        txActive <= 1'b1;
        @(posedge clk_sys);
        txActive <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(dimDisplay, 1'b0);
        repeat (210) @(posedge clk_sys);
        chk({dimDisplay, scrollCall}, 2'b10);
        repeat (200) @(posedge clk_sys);
        chk(scrollCall, 1'b1);
        op_u.press(2, 10);
        chk({dimDisplay, scrollCall}, 2'b00);
        nvValid <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(dispMode, 5'h01);
    endtask : t_saver
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_modes();
        t_style();
        t_regs();
        t_alarm();
        t_snooze();
        t_saver();
        stop_test();
    end
    initial begin
        #60us;
        fail_count++;
        $display("ERROR %0t: watchdog expired", $time);
        stop_test();
    end
endmodule : fpmac_top_bench

// ==== tb/fpmac_top_chk.sv ====
// Purpose: Port assertions for the front-panel control block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to fpmac_top after the module.
module fpmac_top_chk (
    input wire logic clk_sys, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic txActive, // Transmission.
    input wire logic [2:0] nvModeWr, // Stored mode index.
    input wire logic [4:0] dispMode, // Main mode.
    input wire logic showReturnLoss, // Return loss shown.
    input wire logic rearInputSel, // Rear input used.
    input wire logic reactAbs, // Reactance magnitude.
    input wire logic dimDisplay, // First saver step.
    input wire logic scrollCall, // Second saver step.
    input wire logic [2:0] alarmSel, // Set-point index.
    input wire logic [5:0] alarmThresh, // Active threshold.
    input wire logic showUserValue, // User value shown.
    input wire logic alarmSnoozed, // Alarm suppressed.
    input wire logic swrAverage, // Averaged SWR.
    input wire logic [2:0] pwrStyle, // Power style.
    input wire logic [7:0] pwrSuffix, // Indicator character.
    input wire logic [8:0] peakHoldCs, // Active hold.
    input wire logic [3:0] barSpanDb // Active span.
);
    logic [1:0] ageQ; // Edges since reset.
    wire logic settled = (ageQ == 2'h3);
    wire logic [5:0] thrExp = (alarmSel == 3'h0) ? 6'h00 : 6'h0A + 6'h05 * {3'h0, alarmSel};
    // Saturating age counter.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) ageQ <= 2'h0;
        else if (!settled) ageQ <= ageQ + 2'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_mode_step: assert property (
        settled && $changed(dispMode) |->
        dispMode == (($past(dispMode) == 5'h10) ? 5'h01 : $past(dispMode) << 1))
        else $error("mode step wrong");
    a_mode_store: assert property (dispMode == (5'h01 << nvModeWr))
        else $error("stored mode differs");
    a_rl_direct: assert property (
        showReturnLoss == (dispMode != 5'h08) && rearInputSel == (dispMode == 5'h08))
        else $error("direct mode outputs wrong");
    a_react_mag: assert property (reactAbs)
        else $error("reactance not magnitude");
    a_alarm_thr: assert property (
        showUserValue == (alarmSel == 3'h5) && (alarmSel == 3'h5 || alarmThresh == thrExp))
        else $error("threshold wrong");
    a_alarm_next: assert property (
        settled && $changed(alarmSel) |->
        alarmSel == (($past(alarmSel) == 3'h5) ? 3'h0 : $past(alarmSel) + 3'h1))
        else $error("set-point order wrong");
    a_style_next: assert property (
        settled && $changed(pwrStyle) |-> ($past(pwrStyle) == 3'h1 && pwrStyle == 3'h2)
        || ($past(pwrStyle) == 3'h2 && pwrStyle == 3'h4)
        || ($past(pwrStyle) == 3'h4 && pwrStyle == 3'h1))
        else $error("style order wrong");
    a_suffix_char: assert property (
        (pwrStyle == 3'h1 && pwrSuffix == 8'h77) || (pwrStyle == 3'h2 && pwrSuffix == 8'h57)
        || (pwrStyle == 3'h4 && pwrSuffix == 8'h54))
        else $error("suffix wrong");
    a_fixed_tune: assert property (
        (pwrStyle != 3'h4 || peakHoldCs == 9'h019) && (pwrStyle != 3'h2 || barSpanDb == 4'hD))
        else $error("fixed hold or span wrong");
    a_snooze_avg: assert property (swrAverage |-> alarmSnoozed)
        else $error("average outside snooze");
    a_saver_order: assert property (scrollCall |-> dimDisplay)
        else $error("scroll before dim");
    a_tx_wakes: assert property (txActive |-> ##[0:3] !dimDisplay && !scrollCall)
        else $error("transmit did not wake");
    c_wrap: cover property ($past(dispMode) == 5'h10 && dispMode == 5'h01);
    c_snooze: cover property ($rose(alarmSnoozed));
    c_scroll: cover property ($rose(scrollCall));
    c_tune: cover property (pwrStyle == 3'h4);
endmodule : fpmac_top_chk

bind fpmac_top fpmac_top_chk chk_u (.clk_sys, .rst_n, .txActive, .nvModeWr, .dispMode,
    .showReturnLoss, .rearInputSel, .reactAbs, .dimDisplay, .scrollCall, .alarmSel,
    .alarmThresh, .showUserValue, .alarmSnoozed, .swrAverage, .pwrStyle, .pwrSuffix,
    .peakHoldCs, .barSpanDb);
